// [fbcr_regs.sv]
// Chosen here: the address-and-strobe port.
`timescale 1ns/100ps
// Operation
// - writer mode counts each dropped frame
// - bit 31 shows frame available
// - next frame waits for software acknowledge
// - descriptor holds interlace, width, height fields
// - base pointer shows oldest unacknowledged frame
// - ready bit shows reader can accept frame
// - capability returns configured maximum width, height
// - acknowledge bit releases the handled buffer
// - affinity one drops user packets with video
// - affinity zero passes user packets in order
// - delay field defaults one, writable to 4095
// - lock bit enables ratio controlled drop/repeat
// - lock clear lets triple buffer run free
// - rate words hold sixteen-bit rate figures
// - reader base write launches frame read
// - interlace codes 0, 8 and 12
// - acknowledge keeps flag if newer frame waits
// - every register is one 32-bit word
module fbcr_regs
#(
    parameter fbcr_pkg::fbcr_mode_t MODE = fbcr_pkg::FBCR_MODE_WRITER,
    parameter int MAX_WIDTH  = 1920,
    parameter int MAX_HEIGHT = 1080
)
(
    input  wire logic        clk_sys,
    input  wire logic        reset,
    input  wire logic [3:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_write,
    input  wire logic        reg_read,
    output logic [31:0]      reg_rdata,
    input  wire logic        frame_dropped,
    input  wire logic        frame_repeated,
    input  wire logic        wr_done_valid,
    input  wire logic [3:0]  wr_done_ilace,
    input  wire logic [12:0] wr_done_width,
    input  wire logic [12:0] wr_done_height,
    input  wire logic [31:0] wr_done_base,
    output logic             wr_done_ready,
    output logic             buffer_release,
    input  wire logic        rd_ready_in,
    output logic             rd_launch,
    output logic [3:0]       rd_ilace,
    output logic [12:0]      rd_width,
    output logic [12:0]      rd_height,
    output logic [31:0]      rd_base,
    output logic             user_affinity,
    output logic [11:0]      frame_delay,
    output logic             rate_locked,
    output logic [15:0]      in_rate,
    output logic [15:0]      out_rate
);

    // ************************************************************
    // checks and types
    // ************************************************************
    if (MAX_WIDTH < 1 || MAX_WIDTH > 8191 || MAX_HEIGHT < 1 || MAX_HEIGHT > 8191)
    begin : g_bad_size
        $error("maximum frame size does not fit 13 bits");
    end

    localparam logic [12:0] MAX_W13 = 13'(MAX_WIDTH);
    localparam logic [12:0] MAX_H13 = 13'(MAX_HEIGHT);
    localparam bit IS_WRITER = (MODE == fbcr_pkg::FBCR_MODE_WRITER);
    localparam bit IS_READER = (MODE == fbcr_pkg::FBCR_MODE_READER);
    localparam bit IS_BUFFER = (MODE == fbcr_pkg::FBCR_MODE_BUFFER);

    typedef struct packed
    {
        logic [31:0] rdata;
        logic [31:0] drop_cnt;
        logic        release_frame;
        logic        launch;
        logic [3:0]  ilace;
        logic [12:0] width;
        logic [12:0] height;
        logic [31:0] base;
        logic        ready;
        logic        affinity;
        logic [11:0] delay;
        logic        locked;
        logic [15:0] in_rate;
        logic [15:0] out_rate;
    } fbcr_state_t;

    fbcr_state_t st_reg;
    fbcr_state_t st_next;

    // shared packing of interlace, width and height
    function automatic logic [31:0] fbcr_pack_dims(input logic [3:0] il,
                                                   input logic [12:0] w,
                                                   input logic [12:0] h);
        logic [31:0] v;
        v = '0;
        v[fbcr_pkg::ILACE_LSB +: fbcr_pkg::ILACE_W] = il;
        v[fbcr_pkg::WIDTH_LSB +: fbcr_pkg::DIM_W] = w;
        v[fbcr_pkg::HEIGHT_LSB +: fbcr_pkg::DIM_W] = h;
        return v;
    endfunction

    // ************************************************************
    // completed-frame holding for writer mode
    // ************************************************************
    fbcr_frame_if frame_bus ();

    assign frame_bus.valid = IS_WRITER && wr_done_valid;
    assign frame_bus.ilace = wr_done_ilace;
    assign frame_bus.width = wr_done_width;
    assign frame_bus.height = wr_done_height;
    assign frame_bus.base = wr_done_base;

    fbcr_frame_slot u_slot
    (
        .clk_sys       (clk_sys),
        .reset         (reset),
        .release_frame (st_reg.release_frame),
        .fin           (frame_bus.sink)
    );

    logic wr_hit;
    logic rd_hit;
    assign wr_hit = reg_write;
    assign rd_hit = reg_read;

    // ************************************************************
    // next state
    // ************************************************************
    always_comb
    begin
        st_next = st_reg;
        st_next.release_frame = 1'b0;
        st_next.launch = 1'b0;
        st_next.ready = IS_READER && rd_ready_in;

        // writer counts drops, reader and buffer count repeats
        if ((IS_WRITER && frame_dropped) || (!IS_WRITER && frame_repeated))
        begin
            st_next.drop_cnt = st_reg.drop_cnt + 32'h00000001;
        end

        if (wr_hit)
        begin
            unique case (reg_addr)
                fbcr_pkg::IDX_FRAME_DESC:
                begin
                    if (IS_READER)
                    begin
                        st_next.ilace = reg_wdata[fbcr_pkg::ILACE_LSB +: fbcr_pkg::ILACE_W];
                        st_next.width = reg_wdata[fbcr_pkg::WIDTH_LSB +: fbcr_pkg::DIM_W];
                        st_next.height = reg_wdata[fbcr_pkg::HEIGHT_LSB +: fbcr_pkg::DIM_W];
                    end
                end
                fbcr_pkg::IDX_FRAME_BASE:
                begin
                    if (IS_READER)
                    begin
                        st_next.base = reg_wdata;
                        st_next.launch = 1'b1;
                    end
                end
                fbcr_pkg::IDX_MISC:
                begin
                    if (IS_WRITER && reg_wdata[fbcr_pkg::ACK_BIT])
                    begin
                        st_next.release_frame = 1'b1;
                    end
                    st_next.affinity = reg_wdata[fbcr_pkg::AFFINITY_BIT];
                    // zero would stall the buffer, so it is kept out
                    if (reg_wdata[fbcr_pkg::DELAY_LSB +: fbcr_pkg::DELAY_W] != 12'h000)
                    begin
                        st_next.delay = reg_wdata[fbcr_pkg::DELAY_LSB +: fbcr_pkg::DELAY_W];
                    end
                end
                fbcr_pkg::IDX_RATE_LOCK:
                begin
                    if (IS_BUFFER)
                    begin
                        st_next.locked = reg_wdata[fbcr_pkg::LOCK_BIT];
                    end
                end
                fbcr_pkg::IDX_IN_RATE:
                begin
                    if (IS_BUFFER)
                    begin
                        st_next.in_rate = reg_wdata[fbcr_pkg::RATE_W-1:0];
                    end
                end
                fbcr_pkg::IDX_OUT_RATE:
                begin
                    if (IS_BUFFER)
                    begin
                        st_next.out_rate = reg_wdata[fbcr_pkg::RATE_W-1:0];
                    end
                end
                default:
                begin
                end
            endcase
        end

        // read data stand one cycle after the strobe only
        st_next.rdata = 32'h00000000;
        if (rd_hit)
        begin
            unique case (reg_addr)
                fbcr_pkg::IDX_DROP_REPEAT:
                begin
                    st_next.rdata = st_reg.drop_cnt;
                end
                fbcr_pkg::IDX_FRAME_DESC:
                begin
                    if (IS_WRITER)
                    begin
                        st_next.rdata = fbcr_pack_dims(frame_bus.out_ilace,
                                                       frame_bus.out_width,
                                                       frame_bus.out_height);
                        st_next.rdata[fbcr_pkg::AVAIL_BIT] = frame_bus.avail;
                    end
                    else if (IS_READER)
                    begin
                        st_next.rdata = fbcr_pack_dims(st_reg.ilace, st_reg.width,
                                                       st_reg.height);
                    end
                end
                fbcr_pkg::IDX_FRAME_BASE:
                begin
                    if (IS_WRITER)
                    begin
                        st_next.rdata = frame_bus.out_base;
                    end
                    else if (IS_READER)
                    begin
                        st_next.rdata = st_reg.base;
                    end
                end
                fbcr_pkg::IDX_READER_CAP:
                begin
                    if (IS_READER)
                    begin
                        st_next.rdata = fbcr_pack_dims(4'h0, MAX_W13, MAX_H13);
                        st_next.rdata[fbcr_pkg::READY_BIT] = st_reg.ready;
                    end
                end
                fbcr_pkg::IDX_MISC:
                begin
                    st_next.rdata[fbcr_pkg::AFFINITY_BIT] = st_reg.affinity;
                    st_next.rdata[fbcr_pkg::DELAY_LSB +: fbcr_pkg::DELAY_W] = st_reg.delay;
                end
                fbcr_pkg::IDX_RATE_LOCK:
                begin
                    st_next.rdata[fbcr_pkg::LOCK_BIT] = st_reg.locked;
                end
                fbcr_pkg::IDX_IN_RATE:
                begin
                    st_next.rdata[fbcr_pkg::RATE_W-1:0] = st_reg.in_rate;
                end
                fbcr_pkg::IDX_OUT_RATE:
                begin
                    st_next.rdata[fbcr_pkg::RATE_W-1:0] = st_reg.out_rate;
                end
                default:
                begin
                    st_next.rdata = 32'h00000000;
                end
            endcase
        end
    end

    // ************************************************************
    // state register
    // ************************************************************
    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            st_reg <= '0;
            st_reg.delay <= fbcr_pkg::DELAY_RESET;
            st_reg.in_rate <= fbcr_pkg::RATE_RESET;
            st_reg.out_rate <= fbcr_pkg::RATE_RESET;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    // ************************************************************
    // outputs
    // ************************************************************
    // ack is combinational from the slot; accept waits as long as a frame is pending
    assign wr_done_ready = frame_bus.ack;
    assign reg_rdata = st_reg.rdata;
    assign buffer_release = st_reg.release_frame;
    assign rd_launch = st_reg.launch;
    assign rd_ilace = st_reg.ilace;
    assign rd_width = st_reg.width;
    assign rd_height = st_reg.height;
    assign rd_base = st_reg.base;
    assign user_affinity = st_reg.affinity;
    assign frame_delay = st_reg.delay;
    assign rate_locked = st_reg.locked;
    assign in_rate = st_reg.in_rate;
    assign out_rate = st_reg.out_rate;

endmodule // fbcr_regs

// [fbcr_pkg.sv]
package fbcr_pkg;

    // ************************************************************
    // register indices (byte address is four times the index)
    // ************************************************************
    localparam logic [3:0] IDX_DROP_REPEAT = 4'h4;
    localparam logic [3:0] IDX_FRAME_DESC  = 4'h5;
    localparam logic [3:0] IDX_FRAME_BASE  = 4'h6;
    localparam logic [3:0] IDX_READER_CAP  = 4'h7;
    localparam logic [3:0] IDX_MISC        = 4'h8;
    localparam logic [3:0] IDX_RATE_LOCK   = 4'h9;
    localparam logic [3:0] IDX_IN_RATE     = 4'ha;
    localparam logic [3:0] IDX_OUT_RATE    = 4'hb;

    // ************************************************************
    // field positions
    // ************************************************************
    localparam int AVAIL_BIT    = 31;
    localparam int ILACE_LSB    = 26;
    localparam int WIDTH_LSB    = 13;
    localparam int HEIGHT_LSB   = 0;
    localparam int READY_BIT    = 26;
    localparam int ACK_BIT      = 0;
    localparam int AFFINITY_BIT = 1;
    localparam int DELAY_LSB    = 16;
    localparam int LOCK_BIT     = 0;
    localparam int DIM_W        = 13;
    localparam int ILACE_W      = 4;
    localparam int DELAY_W      = 12;
    localparam int RATE_W       = 16;

    // ************************************************************
    // reset values and codes
    // ************************************************************
    localparam logic [11:0] DELAY_RESET  = 12'h001;
    localparam logic [15:0] RATE_RESET   = 16'h0000;
    localparam logic [3:0]  ILACE_PROG   = 4'h0;
    localparam logic [3:0]  ILACE_FIRST  = 4'h8;
    localparam logic [3:0]  ILACE_SECOND = 4'hc;

    typedef enum logic [1:0]
    {
        FBCR_MODE_WRITER,
        FBCR_MODE_READER,
        FBCR_MODE_BUFFER
    } fbcr_mode_t;

endpackage

// [fbcr_frame_if.sv]
`timescale 1ns/100ps
interface fbcr_frame_if;
    logic        valid;
    logic [3:0]  ilace;
    logic [12:0] width;
    logic [12:0] height;
    logic [31:0] base;
    logic        ack;
    logic        avail;
    logic [3:0]  out_ilace;
    logic [12:0] out_width;
    logic [12:0] out_height;
    logic [31:0] out_base;

    modport source
    (
        output valid,
        output ilace,
        output width,
        output height,
        output base,
        input  ack
    );
    modport sink
    (
        input  valid,
        input  ilace,
        input  width,
        input  height,
        input  base,
        output ack,
        output avail,
        output out_ilace,
        output out_width,
        output out_height,
        output out_base
    );
endinterface

// [fbcr_frame_slot.sv]
`timescale 1ns/100ps
// holds the shown frame and one waiting behind it
module fbcr_frame_slot
(
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic release_frame,
    fbcr_frame_if.sink fin
);
    typedef struct packed
    {
        logic        cur_v;
        logic [61:0] cur;
        logic        pend_v;
        logic [61:0] pend;
    } fbcr_slot_t;

    fbcr_slot_t s_reg;
    fbcr_slot_t s_next;
    logic [61:0] incoming;

    assign incoming = {fin.ilace, fin.width, fin.height, fin.base};

    always_comb
    begin
        s_next = s_reg;
        if (release_frame && s_reg.cur_v)
        begin
            // newer completed frame takes over, else flag clears
            s_next.cur_v = s_reg.pend_v;
            s_next.cur = s_reg.pend;
            s_next.pend_v = 1'b0;
        end
        if (fin.valid && fin.ack)
        begin
            if (!s_next.cur_v)
            begin
                s_next.cur_v = 1'b1;
                s_next.cur = incoming;
            end
            else
            begin
                s_next.pend_v = 1'b1;
                s_next.pend = incoming;
            end
        end
    end

    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            s_reg <= '0;
        end
        else
        begin
            s_reg <= s_next;
        end
    end

    // a second waiting frame is back-pressured, not lost
    assign fin.ack = !s_reg.pend_v;
    assign fin.avail = s_reg.cur_v;
    assign fin.out_ilace = s_reg.cur[61:58];
    assign fin.out_width = s_reg.cur[57:45];
    assign fin.out_height = s_reg.cur[44:32];
    assign fin.out_base = s_reg.cur[31:0];
endmodule // fbcr_frame_slot

// [fbcr_regs_props.sv]
`timescale 1ns/100ps
// ************************************************************
// port checker for the register bank
// ************************************************************
module fbcr_regs_props
#(
    parameter fbcr_pkg::fbcr_mode_t MODE = fbcr_pkg::FBCR_MODE_WRITER
)
(
    input wire logic        clk_sys,
    input wire logic        reset,
    input wire logic [3:0]  reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic        reg_write,
    input wire logic        reg_read,
    input wire logic [31:0] reg_rdata,
    input wire logic        buffer_release,
    input wire logic        rd_launch,
    input wire logic [31:0] rd_base,
    input wire logic        user_affinity,
    input wire logic [11:0] frame_delay,
    input wire logic        rate_locked,
    input wire logic [15:0] in_rate
);
    logic misc_wr;
    logic base_wr;
    assign misc_wr = reg_write && reg_addr == fbcr_pkg::IDX_MISC;
    assign base_wr = reg_write && reg_addr == fbcr_pkg::IDX_FRAME_BASE;

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (reset);

    property p_rdata_idle; !$past(reg_read) |-> reg_rdata == 32'h0; endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside slot");
    property p_release;
        MODE == fbcr_pkg::FBCR_MODE_WRITER && misc_wr && reg_wdata[0] |=> buffer_release;
    endproperty
    a_release: assert property (p_release) else $error("ack gave no release");
    property p_release_cause; buffer_release |-> $past(misc_wr && reg_wdata[0]); endproperty
    a_release_cause: assert property (p_release_cause) else $error("stray release");
    property p_launch;
        MODE == fbcr_pkg::FBCR_MODE_READER && base_wr |=> rd_launch && rd_base == $past(reg_wdata);
    endproperty
    a_launch: assert property (p_launch) else $error("base write gave no launch");
    property p_no_launch; MODE == fbcr_pkg::FBCR_MODE_WRITER |-> !rd_launch; endproperty
    a_no_launch: assert property (p_no_launch) else $error("launch in writer mode");
    property p_delay;
        misc_wr && reg_wdata[27:16] != 12'h000 |=> frame_delay == $past(reg_wdata[27:16]);
    endproperty
    a_delay: assert property (p_delay) else $error("delay not taken");
    property p_delay_zero; misc_wr && reg_wdata[27:16] == 12'h000 |=> $stable(frame_delay); endproperty
    a_delay_zero: assert property (p_delay_zero) else $error("zero delay taken");
    property p_affinity; misc_wr |=> user_affinity == $past(reg_wdata[1]); endproperty
    a_affinity: assert property (p_affinity) else $error("affinity not taken");
    property p_lock_na;
        MODE != fbcr_pkg::FBCR_MODE_BUFFER |-> !rate_locked && in_rate == 16'h0000;
    endproperty
    a_lock_na: assert property (p_lock_na) else $error("rate control outside buffer mode");
endmodule // fbcr_regs_props

bind fbcr_regs fbcr_regs_props #(.MODE(MODE)) u_fbcr_regs_props
(
    .clk_sys(clk_sys), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .buffer_release(buffer_release), .rd_launch(rd_launch), .rd_base(rd_base),
    .user_affinity(user_affinity), .frame_delay(frame_delay),
    .rate_locked(rate_locked), .in_rate(in_rate)
);

// [fbcr_regs_tb.sv]
`timescale 1ns/100ps
// ************************************************************
// writer, reader and buffer banks share one bus
// ************************************************************
module fbcr_regs_tb;
    logic        clk_sys, reset, reg_write, reg_read, rd_ready_in;
    logic [3:0]  reg_addr, wr_done_ilace;
    logic [31:0] reg_wdata, wr_done_base, w_rdata, r_rdata, r_base, w, r, b_rdata, b;
    logic        frame_dropped, frame_repeated, wr_done_valid;
    logic [12:0] wr_done_width, wr_done_height, r_width, r_height;
    logic        w_ready, w_release, w_aff, w_lock, r_launch, b_lock;
    logic [11:0] w_delay;
    logic [15:0] w_in_rate, b_in_rate, b_out_rate;
    logic [3:0]  r_ilace;
    int          bad_count, n_tests;
    localparam logic [31:0] CAP = {6'h00, 13'd1280, 13'd720};

    fbcr_regs #(.MODE(fbcr_pkg::FBCR_MODE_WRITER)) u_fbcr_regs
    (
        .clk_sys(clk_sys), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(w_rdata),
        .frame_dropped(frame_dropped), .frame_repeated(frame_repeated),
        .wr_done_valid(wr_done_valid), .wr_done_ilace(wr_done_ilace),
        .wr_done_width(wr_done_width), .wr_done_height(wr_done_height),
        .wr_done_base(wr_done_base), .wr_done_ready(w_ready), .buffer_release(w_release),
        .rd_ready_in(rd_ready_in), .rd_launch(), .rd_ilace(), .rd_width(), .rd_height(),
        .rd_base(), .user_affinity(w_aff), .frame_delay(w_delay), .rate_locked(w_lock),
        .in_rate(w_in_rate), .out_rate()
    );
    // second bank in reader mode, same bus
    fbcr_regs #(.MODE(fbcr_pkg::FBCR_MODE_READER), .MAX_WIDTH(1280), .MAX_HEIGHT(720))
        u_fbcr_regs_rd
    (
        .clk_sys(clk_sys), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(r_rdata),
        .frame_dropped(frame_dropped), .frame_repeated(frame_repeated),
        .wr_done_valid(wr_done_valid), .wr_done_ilace(wr_done_ilace),
        .wr_done_width(wr_done_width), .wr_done_height(wr_done_height),
        .wr_done_base(wr_done_base), .wr_done_ready(), .buffer_release(),
        .rd_ready_in(rd_ready_in), .rd_launch(r_launch), .rd_ilace(r_ilace),
        .rd_width(r_width), .rd_height(r_height), .rd_base(r_base), .user_affinity(),
        .frame_delay(), .rate_locked(), .in_rate(), .out_rate()
    );
    // third bank in buffer mode, same bus
    fbcr_regs #(.MODE(fbcr_pkg::FBCR_MODE_BUFFER)) u_fbcr_regs_buf
    (
        .clk_sys(clk_sys), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(b_rdata),
        .frame_dropped(frame_dropped), .frame_repeated(frame_repeated),
        .wr_done_valid(wr_done_valid), .wr_done_ilace(wr_done_ilace),
        .wr_done_width(wr_done_width), .wr_done_height(wr_done_height),
        .wr_done_base(wr_done_base), .wr_done_ready(), .buffer_release(),
        .rd_ready_in(rd_ready_in), .rd_launch(), .rd_ilace(), .rd_width(), .rd_height(),
        .rd_base(), .user_affinity(), .frame_delay(), .rate_locked(b_lock),
        .in_rate(b_in_rate), .out_rate(b_out_rate)
    );

    // ************************************************************
    // bus tasks
    // ************************************************************
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp)
        begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        reg_write <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_write <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [3:0] a);
        @(posedge clk_sys);
        reg_read <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_read <= 1'b0;
        @(negedge clk_sys);
        w = w_rdata;
        r = r_rdata;
        b = b_rdata;
    endtask

    task automatic send_frame(input logic [3:0] il, input logic [12:0] fw, input logic [12:0] fh,
                              input logic [31:0] fb);
        int k;
        logic rdy;
        k = 0;
        @(posedge clk_sys);
        wr_done_valid  <= 1'b1;
        wr_done_ilace  <= il;
        wr_done_width  <= fw;
        wr_done_height <= fh;
        wr_done_base   <= fb;
        // ready is taken off the edge, so the accepting edge is known
        do
        begin
            @(negedge clk_sys);
            rdy = w_ready;
            @(posedge clk_sys);
            k++;
        end
        while (rdy !== 1'b1 && k < 10);
        wr_done_valid <= 1'b0;
        chk("frame_accept", 32'h1, {31'h0, rdy});
    endtask

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // ************************************************************
    // clock, reset, watchdog
    // ************************************************************
    initial
    begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end

    initial
    begin
        repeat (4000) @(posedge clk_sys);
        bad_count++;
        tally_and_finish();
    end

    // ************************************************************
    // scenarios
    // ************************************************************
    initial
    begin
        {reset, reg_write, reg_read, rd_ready_in} = 4'h8;
        {frame_dropped, frame_repeated, wr_done_valid} = 3'h0;
        {reg_addr, wr_done_ilace} = 8'h00;
        {reg_wdata, wr_done_base} = 64'h0;
        {wr_done_width, wr_done_height} = 26'h0;
        repeat (4) @(posedge clk_sys);
        reset <= 1'b0;
        for (int i = 0; i < 16; i++)
        begin
            rd(i[3:0]);
            chk("reset_writer", (i == 8) ? 32'h0001_0000 : 32'h0, w);
            chk("reset_reader", (i == 8) ? 32'h0001_0000 : (i == 7) ? CAP : 32'h0, r);
            chk("reset_buffer", (i == 8) ? 32'h0001_0000 : 32'h0, b);
        end
        repeat (3)
        begin
            @(posedge clk_sys) frame_dropped <= 1'b1;
            @(posedge clk_sys) frame_dropped <= 1'b0;
        end
        repeat (2)
        begin
            @(posedge clk_sys) frame_repeated <= 1'b1;
            @(posedge clk_sys) frame_repeated <= 1'b0;
        end
        rd(fbcr_pkg::IDX_DROP_REPEAT);
        chk("drop_count", 32'h3, w);
        chk("repeat_count", 32'h2, r);
        chk("buf_repeat_count", 32'h2, b);
        // rate words apply to the buffer bank only
        for (int i = 9; i < 12; i++)
        begin
            wr(i[3:0], 32'hffff_ffff);
            rd(i[3:0]);
            chk("rate_na", 32'h0, w | r);
            chk("rate_buf", (i == 9) ? 32'h1 : 32'hffff, b);
        end
        chk("rate_na_out", 32'h0, {15'h0, w_lock, w_in_rate});
        chk("lock_on", 32'h1_ffff, {15'h0, b_lock, b_in_rate});
        chk("out_rate", 32'hffff, {16'h0, b_out_rate});
        wr(fbcr_pkg::IDX_RATE_LOCK, 32'h0);
        @(negedge clk_sys) chk("lock_off", 32'h0, {31'h0, b_lock});
        send_frame(4'h8, 13'd640, 13'd480, 32'h1000_0000);
        rd(fbcr_pkg::IDX_FRAME_DESC);
        chk("desc_first", {2'b10, 4'h8, 13'd640, 13'd480}, w);
        send_frame(4'hc, 13'd720, 13'd576, 32'h2000_0000);
        rd(fbcr_pkg::IDX_FRAME_BASE);
        chk("base_first", 32'h1000_0000, w);
        rd(fbcr_pkg::IDX_FRAME_DESC);
        chk("desc_held", {2'b10, 4'h8, 13'd640, 13'd480}, w);
        @(posedge clk_sys) wr_done_valid <= 1'b1;
        repeat (3) @(posedge clk_sys);
        @(negedge clk_sys) chk("third_stall", 32'h0, {31'h0, w_ready});
        @(posedge clk_sys) wr_done_valid <= 1'b0;
        wr(fbcr_pkg::IDX_MISC, 32'h0001_0001);
        @(negedge clk_sys) chk("release", 32'h1, {31'h0, w_release});
        rd(fbcr_pkg::IDX_FRAME_DESC);
        chk("desc_second", {2'b10, 4'hc, 13'd720, 13'd576}, w);
        rd(fbcr_pkg::IDX_FRAME_BASE);
        chk("base_second", 32'h2000_0000, w);
        wr(fbcr_pkg::IDX_MISC, 32'h0001_0001);
        rd(fbcr_pkg::IDX_FRAME_DESC);
        chk("avail_clear", 32'h0, {31'h0, w[31]});
        wr(fbcr_pkg::IDX_MISC, 32'hfff_fffe);
        rd(fbcr_pkg::IDX_MISC);
        chk("misc_max", 32'h0fff_0002, w);
        chk("delay_out", 32'hfff, {20'h0, w_delay});
        chk("affinity_on", 32'h1, {31'h0, w_aff});
        wr(fbcr_pkg::IDX_MISC, 32'h0);
        rd(fbcr_pkg::IDX_MISC);
        chk("misc_zero_delay", 32'h0fff_0000, w);
        chk("affinity_off", 32'h0, {31'h0, w_aff});
        wr(fbcr_pkg::IDX_FRAME_DESC, {6'h08, 13'd800, 13'd600});
        rd(fbcr_pkg::IDX_FRAME_DESC);
        chk("reader_desc", {6'h08, 13'd800, 13'd600}, r);
        wr(fbcr_pkg::IDX_FRAME_BASE, 32'h3000_0000);
        @(negedge clk_sys) chk("launch", 32'h1, {31'h0, r_launch});
        chk("launch_base", 32'h3000_0000, r_base);
        chk("launch_desc", {6'h08, 13'd800, 13'd600}, {2'b00, r_ilace, r_width, r_height});
        @(posedge clk_sys) rd_ready_in <= 1'b1;
        rd(fbcr_pkg::IDX_READER_CAP);
        chk("reader_ready", CAP | 32'h0400_0000, r);
        chk("writer_cap_na", 32'h0, w);
        tally_and_finish();
    end
endmodule // fbcr_regs_tb
